/* File: core/cspt_pkg.sv */
// Constants for the clock sources, PLL and tick wheel block
package cspt_pkg;
  // System clock
  localparam int unsigned CLK_HZ = 100_000_000;
  // Main oscillator range select codes
  localparam logic [2:0] MOSC_3M = 3'h0;
  localparam logic [2:0] MOSC_6M = 3'h1;
  localparam logic [2:0] MOSC_12M = 3'h2;
  localparam logic [2:0] MOSC_24M = 3'h3;
  localparam logic [2:0] MOSC_48M = 3'h4;
  localparam logic [2:0] MOSC_74M = 3'h5;
  localparam int unsigned MOSC_RANGES = 6;
  localparam int unsigned TRIM_W = 8;
  // Reference source select codes
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_ROUTE = 2'h2;
  // PLL divider widths: 63 input x 64 feedback settings = 4032 ratios
  localparam int unsigned PLL_Q_W = 6;
  localparam int unsigned PLL_P_W = 6;
  localparam logic [PLL_P_W-1:0] PLL_P_MIN = 6'h01;
  localparam int unsigned PLL_RATIOS = 4032;
  localparam int unsigned PLL_FMIN_MHZ = 24;
  localparam int unsigned PLL_FMAX_MHZ = 80;
  // Lock time, longest: exactly 25000 system cycles
  localparam int unsigned LOCK_TIME_US = 250;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_US * (CLK_HZ / 1_000_000);
  // Slow clock rates in Hz and their tick periods in system cycles
  localparam int unsigned SLOW_1K_HZ = 1_000;
  localparam int unsigned SLOW_33K_HZ = 33_000;
  localparam int unsigned SLOW_100K_HZ = 100_000;
  localparam int unsigned DIV_1K = CLK_HZ / SLOW_1K_HZ;
  localparam int unsigned DIV_33K = CLK_HZ / SLOW_33K_HZ;
  localparam int unsigned DIV_100K = CLK_HZ / SLOW_100K_HZ;
  // Tick wheel
  localparam int unsigned WHEEL_W = 13;
  localparam logic [WHEEL_W-1:0] WHEEL_RST = 13'h0000;
  localparam logic [TRIM_W-1:0] TRIM_RST = 8'h80;
endpackage : cspt_pkg

/* File: core/cspt_clock_sources.sv */
// Clock source control, PLL lock tracking, slow clocks and tick wheel
`timescale 1ns/1ps
module cspt_clock_sources
  import cspt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [2:0] mosc_range_i,
  input wire logic trim_wr_i,
  input wire logic [TRIM_W-1:0] trim_wdata_i,
  input wire logic [1:0] dbl_src_i,
  input wire logic pll_en_i,
  input wire logic [1:0] pll_src_i,
  input wire logic [PLL_Q_W-1:0] pll_q_i,
  input wire logic [PLL_P_W-1:0] pll_p_i,
  input wire logic hibernate_i,
  input wire logic debug_halt_i,
  input wire logic wheel_clr_i,
  input wire logic [WHEEL_W-1:0] wheel_period_i,
  input wire logic [WHEEL_W-1:0] wheel_wake_i,
  input wire logic wake_en_i,
  output logic [2:0] mosc_range_o,
  output logic [TRIM_W-1:0] mosc_trim_o,
  output logic [1:0] dbl_src_o,
  output logic [1:0] pll_src_o,
  output logic [PLL_Q_W-1:0] pll_q_o,
  output logic [PLL_P_W-1:0] pll_p_o,
  output logic pll_lock_o,
  output logic pll_lock_route_o,
  output logic slow_1k_o,
  output logic slow_33k_o,
  output logic slow_100k_o,
  output logic [WHEEL_W-1:0] wheel_count_o,
  output logic wheel_period_o,
  output logic wheel_wake_o
);

  // Per-range trim store; loaded for whichever range is selected
  logic [TRIM_W-1:0] trim_mem_r [MOSC_RANGES];
  logic [2:0] range_r;
  logic [1:0] dbl_src_r;
  logic [1:0] pll_src_r;
  logic [PLL_Q_W-1:0] pll_q_r;
  logic [PLL_P_W-1:0] pll_p_r;
  logic pll_lock_r;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_r;
  logic [$clog2(DIV_1K)-1:0] div1k_r;
  logic [$clog2(DIV_33K)-1:0] div33k_r;
  logic [$clog2(DIV_100K)-1:0] div100k_r;
  logic slow_1k_r;
  logic slow_33k_r;
  logic slow_100k_r;
  logic [WHEEL_W-1:0] wheel_r;
  logic [WHEEL_W-1:0] phase_r;
  logic wheel_period_r;
  logic wheel_wake_r;
  logic [TRIM_W-1:0] trim_out_r;

  // Clamp a select to a legal code so illegal values hold the old one
  function automatic logic src_ok(input logic [1:0] s);
    return (s == SRC_MAIN) || (s == SRC_XTAL) || (s == SRC_ROUTE);
  endfunction : src_ok

  // Selection and decode
  wire range_ok = (mosc_range_i <= MOSC_74M);
  wire [2:0] range_nxt = range_ok ? mosc_range_i : range_r;
  wire [1:0] dbl_src_nxt = src_ok(dbl_src_i) ? dbl_src_i : dbl_src_r;
  wire [1:0] pll_src_nxt = src_ok(pll_src_i) ? pll_src_i : pll_src_r;
  // Input divider zero is not a legal ratio; 64 x 63 settings remain
  wire [PLL_P_W-1:0] pll_p_nxt = (pll_p_i >= PLL_P_MIN) ? pll_p_i : pll_p_r;
  wire [PLL_Q_W-1:0] pll_q_nxt = pll_q_i;
  wire pll_cfg_chg = (pll_src_nxt != pll_src_r) || (pll_q_nxt != pll_q_r) || (pll_p_nxt != pll_p_r);
  wire lock_done = (lock_cnt_r == LOCK_CYCLES[$bits(lock_cnt_r)-1:0]);
  wire wheel_run = !hibernate_i && !debug_halt_i;
  wire tick_1k = (div1k_r == DIV_1K[$bits(div1k_r)-1:0] - 1'b1);
  wire wheel_step = tick_1k && wheel_run;
  wire [WHEEL_W-1:0] wheel_inc = wheel_r + 1'b1;
  wire period_hit = (wheel_period_i != WHEEL_RST) && (phase_r == wheel_period_i - 1'b1);

  // Configuration registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      range_r <= MOSC_3M;
      dbl_src_r <= SRC_MAIN;
      pll_src_r <= SRC_MAIN;
      pll_q_r <= '0;
      pll_p_r <= PLL_P_MIN;
    end else if (ce_i) begin
      range_r <= range_nxt;
      dbl_src_r <= dbl_src_nxt;
      pll_src_r <= pll_src_nxt;
      pll_q_r <= pll_q_nxt;
      pll_p_r <= pll_p_nxt;
    end
  end

  // Trim store written for the currently selected range
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < MOSC_RANGES; i++) begin
        trim_mem_r[i] <= TRIM_RST;
      end
      trim_out_r <= TRIM_RST;
    end else if (ce_i) begin
      if (trim_wr_i) begin
        trim_mem_r[range_r] <= trim_wdata_i;
      end
      trim_out_r <= trim_mem_r[range_nxt];
    end
  end

  // Lock tracking: restart on disable or any PLL source or divider change
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_cnt_r <= '0;
      pll_lock_r <= 1'b0;
    end else if (ce_i) begin
      if (!pll_en_i || pll_cfg_chg) begin
        lock_cnt_r <= '0;
        pll_lock_r <= 1'b0;
      end else if (!lock_done) begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end else begin
        pll_lock_r <= 1'b1;
      end
    end
  end

  // Slow clocks: half-period toggles give an even duty cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div1k_r <= '0;
      div33k_r <= '0;
      div100k_r <= '0;
      slow_1k_r <= 1'b0;
      slow_33k_r <= 1'b0;
      slow_100k_r <= 1'b0;
    end else if (ce_i) begin
      div1k_r <= tick_1k ? '0 : div1k_r + 1'b1;
      if (div1k_r == DIV_1K[$bits(div1k_r)-1:0] / 2 - 1'b1 || tick_1k) begin
        slow_1k_r <= ~slow_1k_r;
      end
      if (div33k_r == DIV_33K[$bits(div33k_r)-1:0] / 2 - 1'b1) begin
        div33k_r <= '0;
        slow_33k_r <= ~slow_33k_r;
      end else begin
        div33k_r <= div33k_r + 1'b1;
      end
      if (div100k_r == DIV_100K[$bits(div100k_r)-1:0] / 2 - 1'b1) begin
        div100k_r <= '0;
        slow_100k_r <= ~slow_100k_r;
      end else begin
        div100k_r <= div100k_r + 1'b1;
      end
    end
  end

  // Tick wheel and its events; clear wins over a step in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wheel_r <= WHEEL_RST;
      phase_r <= WHEEL_RST;
      wheel_period_r <= 1'b0;
      wheel_wake_r <= 1'b0;
    end else if (ce_i) begin
      wheel_period_r <= 1'b0;
      wheel_wake_r <= 1'b0;
      if (wheel_clr_i) begin
        wheel_r <= WHEEL_RST;
        phase_r <= WHEEL_RST;
      end else if (wheel_step) begin
        wheel_r <= wheel_inc;
        phase_r <= period_hit ? WHEEL_RST : phase_r + 1'b1;
        wheel_period_r <= period_hit;
        wheel_wake_r <= wake_en_i && (wheel_inc == wheel_wake_i);
      end
    end
  end

  assign mosc_range_o = range_r;
  assign mosc_trim_o = trim_out_r;
  assign dbl_src_o = dbl_src_r;
  assign pll_src_o = pll_src_r;
  assign pll_q_o = pll_q_r;
  assign pll_p_o = pll_p_r;
  assign pll_lock_o = pll_lock_r;
  assign pll_lock_route_o = pll_lock_r;
  assign slow_1k_o = slow_1k_r;
  assign slow_33k_o = slow_33k_r;
  assign slow_100k_o = slow_100k_r;
  assign wheel_count_o = wheel_r;
  assign wheel_period_o = wheel_period_r;
  assign wheel_wake_o = wheel_wake_r;

  // Lock must fall the cycle after disable
  AST_LOCK_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !pll_en_i |=> !pll_lock_o)
    else $error("lock held while disabled");
  // Lock never rises sooner than the lock count after a restart
  AST_LOCK_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(pll_lock_o) |-> lock_done)
    else $error("lock rose early");
  // Routed lock tracks status bit
  AST_LOCK_ROUTE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pll_lock_route_o == pll_lock_o)
    else $error("routed lock differs");
  // Wheel clear gives zero next
  AST_WHEEL_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && wheel_clr_i |=> wheel_count_o == WHEEL_RST)
    else $error("wheel not cleared");
  // Wheel frozen while halted
  AST_WHEEL_HALT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (hibernate_i || debug_halt_i) && !wheel_clr_i |=> $stable(wheel_count_o))
    else $error("wheel ran halted");
  // Wheel steps by one or wraps
  AST_WHEEL_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && wheel_step && !wheel_clr_i |=> wheel_count_o == $past(wheel_count_o) + 13'h0001)
    else $error("wheel bad step");
  // Max value wraps to zero
  AST_WHEEL_WRAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && wheel_step && !wheel_clr_i && wheel_count_o == 13'h1FFF |=> wheel_count_o == 13'h0000)
    else $error("wheel no wrap");
  // Wake pulse only when count matches
  AST_WAKE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wheel_wake_o |-> wheel_count_o == $past(wheel_wake_i))
    else $error("wake mismatch");
  // Main range stays legal
  AST_RANGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mosc_range_o <= MOSC_74M)
    else $error("illegal range");
  // Slow 100k toggles on its count
  AST_SLOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(slow_100k_o) |-> $past(div100k_r) == DIV_100K[$bits(div100k_r)-1:0] / 2 - 1'b1)
    else $error("100k bad toggle");
  // Slow 33k toggles only at its half count
  AST_SLOW_33K: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(slow_33k_o) |-> $past(div33k_r) == DIV_33K[$bits(div33k_r)-1:0] / 2 - 1'b1)
    else $error("33k bad toggle");
  // Slow 1k toggles at half count or at the wrap tick
  AST_SLOW_1K: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(slow_1k_o) |-> $past(div1k_r) == DIV_1K[$bits(div1k_r)-1:0] / 2 - 1'b1 || $past(tick_1k))
    else $error("1k bad toggle");
  // A legal reconfiguration drops lock next cycle
  AST_LOCK_CHG: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && pll_en_i && pll_cfg_chg |=> !pll_lock_o)
    else $error("lock held across change");
  // Full count with steady settings sets lock
  AST_LOCK_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && pll_en_i && !pll_cfg_chg && lock_done |=> pll_lock_o)
    else $error("lock not set");
  // Lock only stands while the count is full
  AST_LOCK_FULL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pll_lock_o |-> lock_done)
    else $error("lock without full count");
  // Legal range codes are taken next cycle
  AST_RANGE_TAKE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && range_ok |=> mosc_range_o == $past(mosc_range_i))
    else $error("range not taken");
  // Illegal range codes leave the range alone
  AST_RANGE_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !range_ok |=> $stable(mosc_range_o))
    else $error("illegal range taken");
  // Refused doubler source leaves the source alone
  AST_DBL_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !src_ok(dbl_src_i) |=> $stable(dbl_src_o))
    else $error("doubler source refused code taken");
  // Refused reference source leaves the source alone
  AST_SRC_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !src_ok(pll_src_i) |=> $stable(pll_src_o))
    else $error("reference refused code taken");
  // Zero input divider is refused
  AST_P_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && pll_p_i < PLL_P_MIN |=> $stable(pll_p_o))
    else $error("zero divider taken");
  // Feedback divider takes any value next cycle
  AST_Q_TAKE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i |=> pll_q_o == $past(pll_q_i))
    else $error("feedback divider not taken");
  // Wheel moves only on a 1 kHz tick or a clear
  AST_WHEEL_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !wheel_clr_i && !wheel_step |=> $stable(wheel_count_o))
    else $error("wheel moved between ticks");
  // Wake pulse needs the enable
  AST_WAKE_EN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wheel_wake_o |-> $past(wake_en_i))
    else $error("wake without enable");
  // Period pulse only comes with a wheel step
  AST_PERIOD_STEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wheel_period_o |-> wheel_count_o != $past(wheel_count_o))
    else $error("period pulse without step");
  // Low enable freezes the state behind the outputs
  AST_FREEZE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ce_i |=> $stable(wheel_count_o) && $stable(pll_lock_o) && $stable(mosc_trim_o) && $stable(slow_1k_o))
    else $error("state moved with enable low");

endmodule : cspt_clock_sources

/* File: sim/cspt_consumer_model.sv */
// Clock consumer model: follows the lock bit and times the slow clock halves
`timescale 1ns/1ps
module cspt_consumer_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic lock_i,
  input wire logic [1:0] slow_i,
  output logic use_pll_o,
  output logic [1:0][15:0] half_o
);
  logic [1:0][15:0] cnt_r;
  logic [1:0] prev_r;
  // Consumers stay on the reference clock until lock is reported
  assign use_pll_o = lock_i;
  // Half period lengths; the first half after reset starts with the divider, so it is full length and is overwritten later
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= 2'h0;
      cnt_r <= '0;
      half_o <= '0;
    end else begin
      prev_r <= slow_i;
      for (int k = 0; k < 2; k++) begin
        if (slow_i[k] != prev_r[k]) begin
          half_o[k] <= cnt_r[k];
          cnt_r[k] <= 16'h0001;
        end else begin
          cnt_r[k] <= cnt_r[k] + 16'h0001;
        end
      end
    end
  end
endmodule : cspt_consumer_model

/* File: sim/tb_top.sv */
// Self-checking bench for the clock sources, PLL lock and tick wheel block
`timescale 1ns/1ps
module tb_top;
  import cspt_pkg::*;
  logic clk_i, rstn_i, ce_i, trim_wr_i, pll_en_i, hibernate_i, debug_halt_i, wheel_clr_i, wake_en_i;
  logic [2:0] mosc_range_i, mosc_range_o;
  logic [TRIM_W-1:0] trim_wdata_i, mosc_trim_o;
  logic [1:0] dbl_src_i, pll_src_i, dbl_src_o, pll_src_o;
  logic [PLL_Q_W-1:0] pll_q_i, pll_q_o;
  logic [PLL_P_W-1:0] pll_p_i, pll_p_o;
  logic [WHEEL_W-1:0] wheel_period_i, wheel_wake_i, wheel_count_o;
  logic pll_lock_o, pll_lock_route_o, slow_1k_o, slow_33k_o, slow_100k_o, wheel_period_o, wheel_wake_o;
  logic use_pll;
  logic [1:0][15:0] half;
  int m_range, m_dbl, m_src, m_q, m_p, mismatches, checked, cyc, w, i;
  int m_trim [8];
  cspt_clock_sources i_dut (.clk_i, .rstn_i, .ce_i, .mosc_range_i, .trim_wr_i, .trim_wdata_i, .dbl_src_i,
    .pll_en_i, .pll_src_i, .pll_q_i, .pll_p_i, .hibernate_i, .debug_halt_i, .wheel_clr_i, .wheel_period_i,
    .wheel_wake_i, .wake_en_i, .mosc_range_o, .mosc_trim_o, .dbl_src_o, .pll_src_o, .pll_q_o, .pll_p_o,
    .pll_lock_o, .pll_lock_route_o, .slow_1k_o, .slow_33k_o, .slow_100k_o, .wheel_count_o,
    .wheel_period_o, .wheel_wake_o);
  cspt_consumer_model i_model (.clk_i(clk_i), .rstn_i(rstn_i), .lock_i(pll_lock_o),
    .slow_i({slow_33k_o, slow_100k_o}), .use_pll_o(use_pll), .half_o(half));
  // Clock, and a hang guard well above the expected run length
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      results();
    end
  end
  task results;
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  // Inputs always move 1 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task cfg_check;
    chk(m_range, mosc_range_o);
    chk(m_trim[m_range], mosc_trim_o);
    chk(m_dbl, dbl_src_o);
    chk(m_src, pll_src_o);
    chk(m_q, pll_q_o);
    chk(m_p, pll_p_o);
  endtask : cfg_check
  // Bounded wait; a late lock leaves the flag low and the next compare fails
  task wait_lock;
    for (w = 0; w < 40 && pll_lock_o !== 1'b1; w++) step(1);
  endtask : wait_lock
  initial begin
    void'($urandom(32'h4b81_b3cc));
    {ce_i, trim_wr_i, pll_en_i, hibernate_i, debug_halt_i, wheel_clr_i, wake_en_i} = 7'h40;
    {mosc_range_i, trim_wdata_i, dbl_src_i, pll_src_i, pll_q_i} = '0;
    {pll_p_i, wheel_period_i, wheel_wake_i} = {6'h01, 26'h000_0000};
    {m_range, m_dbl, m_src, m_q, m_p} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
    foreach (m_trim[k]) m_trim[k] = TRIM_RST;
    rstn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    cfg_check();
    chk(0, pll_lock_o);
    chk(0, wheel_count_o);
    chk(0, {slow_1k_o, slow_33k_o, slow_100k_o});
    // Every range code, two of them illegal, each with a fresh trim
    for (i = 0; i < 8; i++) begin
      mosc_range_i = 3'(i);
      if (i < 6) m_range = i;
      step(1);
      trim_wr_i = 1'b1;
      trim_wdata_i = 8'($urandom);
      m_trim[m_range] = trim_wdata_i;
      step(1);
      trim_wr_i = 1'b0;
      step(1);
      cfg_check();
    end
    // Trims are kept per range
    for (i = 0; i < 6; i++) begin
      mosc_range_i = 3'(i);
      m_range = i;
      step(2);
      chk(m_trim[i], mosc_trim_o);
    end
    // Every source code and random dividers; code 3 and p of zero are refused
    for (i = 0; i < 4; i++) begin
      {dbl_src_i, pll_src_i} = {i[1:0], i[1:0]};
      if (i < 3) {m_dbl, m_src} = {i, i};
      pll_p_i = (i == 3) ? 6'h00 : 6'($urandom_range(63, 1));
      if (i < 3) m_p = pll_p_i;
      pll_q_i = 6'($urandom);
      m_q = pll_q_i;
      step(2);
      cfg_check();
    end
    // Clock enable low freezes the configuration
    ce_i = 1'b0;
    mosc_range_i = 3'h1;
    step(3);
    chk(m_range, mosc_range_o);
    ce_i = 1'b1;
    m_range = 1;
    step(2);
    chk(m_trim[1], mosc_trim_o);
    // Wheel clear and stop inputs, with random event settings
    {wheel_period_i, wheel_wake_i, wake_en_i, wheel_clr_i} = {13'($urandom), 13'($urandom), 2'h3};
    step(2);
    chk(0, wheel_count_o);
    chk(0, {wheel_period_o, wheel_wake_o});
    {wheel_clr_i, debug_halt_i} = 2'h1;
    step(3);
    chk(0, wheel_count_o);
    debug_halt_i = 1'b0;
    // Lock after enable, routed copy and consumer switch-over
    pll_en_i = 1'b1;
    step(24990);
    chk(0, pll_lock_o);
    wait_lock();
    chk(1, pll_lock_o);
    chk(1, pll_lock_route_o);
    chk(1, use_pll);
    // A refused divider value keeps lock; a legal change drops and relocks
    pll_p_i = 6'h00;
    step(3);
    chk(1, pll_lock_o);
    chk(m_p, pll_p_o);
    m_q = (m_q + 1) % 64;
    pll_q_i = 6'(m_q);
    step(2);
    chk(0, pll_lock_o);
    step(24985);
    chk(0, pll_lock_o);
    wait_lock();
    chk(1, pll_lock_o);
    // PLL off before hibernate, which stops the wheel
    pll_en_i = 1'b0;
    step(2);
    chk(0, pll_lock_o);
    hibernate_i = 1'b1;
    step(3);
    chk(0, wheel_count_o);
    hibernate_i = 1'b0;
    chk(DIV_100K / 2, half[0]);
    chk(DIV_33K / 2, half[1]);
    // About 50060 enabled cycles have passed: one 1 kHz half period of 50000 is done
    chk(1, slow_1k_o);
    results();
  end
endmodule : tb_top
